// ===== dv/motion_stage_model.sv
// Behavioural motion stage answering reference movement requests
`timescale 1ns/1ps
module motion_stage_model (
  input  wire logic       core_clk_in,
  input  wire logic       rst_b_in,
  input  wire logic       ref_move_req_in,
  input  wire logic       fail_cmd_in,
  input  wire logic [7:0] delay_in,
  input  wire logic       still_en_in,
  output logic            ref_move_done_out,
  output logic            ref_move_fail_out,
  output logic            standstill_out
);
  logic [7:0] wait_reg;

  // Axis never reports standstill while a reference run is under way
  assign standstill_out = still_en_in & ~ref_move_req_in;

  always_ff @(posedge core_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      wait_reg          <= 8'h00;
      ref_move_done_out <= 1'b0;
      ref_move_fail_out <= 1'b0;
    end
    else
    begin
      ref_move_done_out <= 1'b0;
      ref_move_fail_out <= 1'b0;
      if (!ref_move_req_in)
        wait_reg <= 8'h00;
      else
      begin
        wait_reg <= wait_reg + 8'h01;
        // Counter moves past the delay, so only one pulse per run
        if (wait_reg == delay_in)
        begin
          ref_move_done_out <= ~fail_cmd_in;
          ref_move_fail_out <= fail_cmd_in;
        end
      end
    end
  end
endmodule

// ===== dv/test_gear_offset_positioning.sv
// Self-checking bench for offset positioning and referencing
`timescale 1ns/1ps
module test_gear_offset_positioning;
  import gear_offset_pkg::*;
  logic        core_clk_in = 1'b0;
  logic        rst_b_in    = 1'b0;
  logic        wr_s        = 1'b0;
  logic        rd_s        = 1'b0;
  logic [15:0] key         = 16'h0000;
  logic [31:0] wdata       = 32'h0000_0000;
  logic [31:0] rdata;
  logic        perr;
  logic        gmode       = 1'b0;
  logic        gproc       = 1'b0;
  logic [31:0] gsp         = 32'h0000_1000;
  logic [31:0] psp;
  logic [6:0]  errs        = 7'h00;
  logic        fail_cmd    = 1'b0;
  logic        still_en    = 1'b0;
  logic [7:0]  dly         = 8'h08;
  logic        done, fail, still, req, lock, preset;
  logic [3:0]  rtype;
  logic [31:0] pval, rd_val, sp;
  logic        rd_err;
  int          err_total   = 0;
  int          checks_done = 0;
  int          preset_cnt  = 0;

  always #4 core_clk_in = ~core_clk_in;
  always @(posedge core_clk_in) if (preset === 1'b1) preset_cnt++;

  gear_offset_positioning #(.CTRL_CLKS(4)) DUT (
    .core_clk_in(core_clk_in), .rst_b_in(rst_b_in),
    .param_wr_in(wr_s), .param_rd_in(rd_s),
    .param_index_in(key[15:8]), .param_subindex_in(key[7:0]),
    .param_wdata_in(wdata), .param_rdata_out(rdata), .param_err_out(perr),
    .gear_mode_in(gmode), .gear_proc_active_in(gproc),
    .gear_setpoint_in(gsp), .position_setpoint_out(psp),
    .positive_limit_switch_in(errs[0]), .negative_limit_switch_in(errs[1]),
    .hardware_stop_input_in(errs[2]), .reference_switch_stop_in(errs[3]),
    .soft_positive_limit_in(errs[4]), .soft_negative_limit_in(errs[5]),
    .soft_stop_in(errs[6]), .standstill_in(still),
    .ref_move_done_in(done), .ref_move_fail_in(fail),
    .ref_move_req_out(req), .ref_move_type_out(rtype),
    .mode_change_lock_out(lock), .pos_preset_out(preset),
    .pos_preset_value_out(pval));

  motion_stage_model stage (
    .core_clk_in(core_clk_in), .rst_b_in(rst_b_in), .ref_move_req_in(req),
    .fail_cmd_in(fail_cmd), .delay_in(dly), .still_en_in(still_en),
    .ref_move_done_out(done), .ref_move_fail_out(fail), .standstill_out(still));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      err_total++;
      $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic finish_test();
    $display("Checks %0d, mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // Refusal pulse may land on the edge that takes the write or on the next one
  task automatic wr(input logic [15:0] k, input logic [31:0] d, input logic exp_err);
    logic seen;
    @(posedge core_clk_in);
    wr_s  <= 1'b1;
    key   <= k;
    wdata <= d;
    @(posedge core_clk_in);
    wr_s <= 1'b0;
    #1 seen = perr;
    @(posedge core_clk_in);
    #1 seen = seen | perr;
    check({31'h0, seen}, {31'h0, exp_err});
  endtask

  task automatic rd(input logic [15:0] k);
    @(posedge core_clk_in);
    rd_s <= 1'b1;
    key  <= k;
    @(posedge core_clk_in);
    rd_s <= 1'b0;
    #1 rd_val = rdata;
    rd_err = perr;
  endtask

  task automatic wait_end();
    for (int i = 0; i < 100; i++)
    begin
      rd(KEY_OFS_STATUS);
      if (rd_val[BIT_MOTION_END] === 1'b1)
        return;
    end
    check(32'h0000_0000, 32'h0000_0001);
    finish_test();
  endtask

  task automatic wait_idle();
    for (int i = 0; i < 60; i++)
    begin
      @(posedge core_clk_in);
      if (req === 1'b0)
        return;
    end
    check(32'h0000_0000, 32'h0000_0001);
    finish_test();
  endtask

  initial
  begin
    repeat (8) @(posedge core_clk_in);
    rst_b_in <= 1'b1;
    rd(KEY_ABS_TARGET);  check(rd_val, 32'h0000_0000);
    rd(KEY_REL_TRAVEL);  check(rd_val, 32'h0000_0000);
    rd(KEY_ORIGIN_SIZE); check(rd_val, 32'h0000_0000);
    rd(KEY_SPEED_SET);   check(rd_val, 32'h0000_003c);
    rd(KEY_ACCEL_RAMP);  check(rd_val, 32'h0000_0258);
    rd(KEY_DECEL_RAMP);  check(rd_val, 32'h0000_0258);
    check(psp, 32'h0000_1000);
    rd(16'h27ff); check({31'h0, rd_err}, 32'h0000_0001);
    wr(KEY_OFS_STATUS, 32'h0000_0001, 1'b1);
    // Gear off: offset lands at once, no ramps
    wr(KEY_ABS_TARGET, 32'h0000_0064, 1'b0);
    rd(KEY_MON_POSITION); check(rd_val, 32'h0000_0064);
    rd(KEY_OFS_STATUS);   check(rd_val, 32'h0000_6000);
    check(psp, 32'h0000_1064);
    wr(KEY_REL_TRAVEL, 32'hffff_ffec, 1'b0);
    rd(KEY_MON_TARGET); check(rd_val, 32'h0000_0050);
    // Gear on: ramped move
    gmode <= 1'b1;
    gproc <= 1'b1;
    wr(KEY_SPEED_SET, 32'h0000_000a, 1'b0);
    wr(KEY_ABS_TARGET, 32'h0000_00c8, 1'b0);
    rd(KEY_OFS_STATUS); check(rd_val & 32'h0000_e000, 32'h0000_0000);
    wait_end();
    check(rd_val, 32'h0000_6000);
    rd(KEY_MON_POSITION); check(rd_val, 32'h0000_00c8);
    gsp <= 32'h0000_2000;
    repeat (2) @(posedge core_clk_in);
    #1 check(psp, 32'h0000_20c8);
    // Mode change in mid-move
    wr(KEY_REL_TRAVEL, 32'h0000_03e8, 1'b0);
    repeat (6) @(posedge core_clk_in);
    gmode <= 1'b0;
    repeat (3) @(posedge core_clk_in);
    rd(KEY_OFS_STATUS);  check(rd_val, 32'h0000_c000);
    rd(KEY_MON_SPEED);   check(rd_val, 32'h0000_0000);
    rd(KEY_MON_TARGET);  sp = rd_val;
    rd(KEY_MON_POSITION); check(rd_val, sp);
    gmode <= 1'b1;
    // Each error cause aborts and shows in its own bit
    for (int i = 0; i < 7; i++)
    begin
      wr(KEY_REL_TRAVEL, 32'h0000_03e8, 1'b0);
      rd(KEY_OFS_STATUS); check(rd_val & 32'h0000_e000, 32'h0000_0000);
      errs <= 7'h01 << i;
      repeat (2) @(posedge core_clk_in);
      rd(KEY_OFS_STATUS);
      check(rd_val, 32'h0000_c000 | (32'h1 << ((i < 4) ? i : i + 1)));
      errs <= 7'h00;
    end
    sp = psp;
    wr(KEY_ORIGIN_SIZE, 32'h0000_1388, 1'b0);
    rd(KEY_MON_POSITION); check(rd_val, 32'h0000_1388);
    check(psp, sp);
    // Referencing
    rd(KEY_MODE_STATUS); check(rd_val & 32'h0000_0020, 32'h0000_0000);
    wr(KEY_REF_START, 32'h0000_0000, 1'b1);
    wr(KEY_REF_START, 32'h0000_0009, 1'b1);
    for (int t = 1; t < 9; t++)
    begin
      dly <= 8'(12 - t);
      wr(KEY_REF_START, 32'(t), 1'b0);
      check({28'h0, rtype}, 32'(t));
      check({31'h0, lock}, 32'h0000_0001);
      if (t == 1)
        wr(KEY_REF_START, 32'h0000_0002, 1'b1);
      wait_idle();
      rd(KEY_MODE_STATUS); check(rd_val & 32'h0000_0020, 32'h0000_0020);
    end
    rd(KEY_REF_STATUS); check(rd_val & 32'h0000_c000, 32'h0000_4000);
    fail_cmd <= 1'b1;
    wr(KEY_REF_START, 32'h0000_0001, 1'b0);
    wait_idle();
    rd(KEY_MODE_STATUS); check(rd_val & 32'h0000_0020, 32'h0000_0000);
    rd(KEY_REF_STATUS); check(rd_val & 32'h0000_c000, 32'h0000_c000);
    fail_cmd <= 1'b0;
    // Dimension setting needs standstill
    wr(KEY_DIM_SET, 32'h0000_007b, 1'b1);
    check(32'(preset_cnt), 32'h0000_0000);
    still_en <= 1'b1;
    wr(KEY_DIM_SET, 32'h0000_007b, 1'b0);
    check(32'(preset_cnt), 32'h0000_0001);
    check(pval, 32'h0000_007b);
    rd(KEY_MODE_STATUS); check(rd_val & 32'h0000_0020, 32'h0000_0020);
    finish_test();
  end
endmodule

// ===== inc/gear_offset_pkg.sv
// Parameter keys, field layouts, reset values and timing for offset positioning
package gear_offset_pkg;

  // Parameter keys: index in the high byte, subindex in the low byte
  localparam logic [15:0] KEY_ABS_TARGET   = 16'h2701;
  localparam logic [15:0] KEY_OFS_STATUS   = 16'h2702;
  localparam logic [15:0] KEY_REL_TRAVEL   = 16'h2703;
  localparam logic [15:0] KEY_SPEED_SET    = 16'h2705;
  localparam logic [15:0] KEY_ORIGIN_SIZE  = 16'h2706;
  localparam logic [15:0] KEY_ACCEL_RAMP   = 16'h2707;
  localparam logic [15:0] KEY_DECEL_RAMP   = 16'h2708;
  localparam logic [15:0] KEY_REF_START    = 16'h2801;
  localparam logic [15:0] KEY_REF_STATUS   = 16'h2802;
  localparam logic [15:0] KEY_DIM_SET      = 16'h2803;
  localparam logic [15:0] KEY_MODE_STATUS  = 16'h1c03;
  localparam logic [15:0] KEY_MON_TARGET   = 16'h1f29;
  localparam logic [15:0] KEY_MON_POSITION = 16'h1f2a;
  localparam logic [15:0] KEY_MON_SPEED    = 16'h1f2b;

  // Status word bit positions
  localparam int unsigned BIT_UNUSED       = 4;
  localparam int unsigned BIT_SET_REACHED  = 13;
  localparam int unsigned BIT_MOTION_END   = 14;
  localparam int unsigned BIT_MOTION_ERR   = 15;
  localparam int unsigned BIT_REF_OK       = 5;

  // Reset values
  localparam logic [31:0] RST_ABS_TARGET   = 32'h0000_0000;
  localparam logic [31:0] RST_REL_TRAVEL   = 32'h0000_0000;
  localparam logic [31:0] RST_SPEED_SET    = 32'h0000_003c;
  localparam logic [31:0] RST_ORIGIN_SIZE  = 32'h0000_0000;
  localparam logic [31:0] RST_ACCEL_RAMP   = 32'h0000_0258;
  localparam logic [31:0] RST_DECEL_RAMP   = 32'h0000_0258;

  // Speed ceiling in increments per control cycle
  localparam logic [15:0] SPEED_LIMIT      = 16'h2ee0;
  // Ramp in r.p.m/s scaled down to increments per cycle per cycle
  localparam int unsigned RAMP_SHIFT       = 6;
  localparam logic [3:0]  REF_TYPE_MAX     = 4'h8;

  // Control cycle timing
  localparam int unsigned CLK_PERIOD_NS    = 8;
  localparam int unsigned CTRL_CYCLE_NS    = 1000000;
  localparam int unsigned CTRL_CYCLE_CLKS  = CTRL_CYCLE_NS / CLK_PERIOD_NS;

  typedef enum logic [1:0] {
    OFS_IDLE = 2'b01,
    OFS_RUN  = 2'b10
  } ofs_state_t;

  typedef enum logic [1:0] {
    REF_IDLE = 2'b01,
    REF_MOVE = 2'b10
  } ref_state_t;

endpackage

// ===== logic/gear_offset_positioning.sv
// Offset positioning superimposed on electronic gear, plus referencing control
`timescale 1ns/1ps
module gear_offset_positioning
  import gear_offset_pkg::*;
#(
  parameter int unsigned CTRL_CLKS = gear_offset_pkg::CTRL_CYCLE_CLKS
)(
  input  wire logic        core_clk_in,
  input  wire logic        rst_b_in,
  input  wire logic        param_wr_in,
  input  wire logic        param_rd_in,
  input  wire logic [7:0]  param_index_in,
  input  wire logic [7:0]  param_subindex_in,
  input  wire logic [31:0] param_wdata_in,
  output logic      [31:0] param_rdata_out,
  output logic             param_err_out,
  input  wire logic        gear_mode_in,
  input  wire logic        gear_proc_active_in,
  input  wire logic [31:0] gear_setpoint_in,
  output logic      [31:0] position_setpoint_out,
  input  wire logic        positive_limit_switch_in,
  input  wire logic        negative_limit_switch_in,
  input  wire logic        hardware_stop_input_in,
  input  wire logic        reference_switch_stop_in,
  input  wire logic        soft_positive_limit_in,
  input  wire logic        soft_negative_limit_in,
  input  wire logic        soft_stop_in,
  input  wire logic        standstill_in,
  input  wire logic        ref_move_done_in,
  input  wire logic        ref_move_fail_in,
  output logic             ref_move_req_out,
  output logic      [3:0]  ref_move_type_out,
  output logic             mode_change_lock_out,
  output logic             pos_preset_out,
  output logic      [31:0] pos_preset_value_out
);
  import gear_offset_pkg::*;

  typedef struct packed {
    ofs_state_t  ofs;
    ref_state_t  refs;
    logic [19:0] tick;
    logic [31:0] abs_tgt;
    logic [31:0] rel_trv;
    logic [31:0] spd_set;
    logic [31:0] acc;
    logic [31:0] dec;
    logic [31:0] sizing;
    logic [31:0] tgt;
    logic [31:0] pos;
    logic [31:0] delta;
    logic [15:0] spd;
    logic        dir_neg;
    logic [15:0] ofs_stat;
    logic [15:0] ref_stat;
    logic        ref_ok;
    logic [3:0]  ref_type;
    logic        preset;
    logic [31:0] preset_val;
    logic [31:0] applied;
    logic [31:0] setpoint;
    logic [31:0] rdata;
    logic        err;
  } state_t;

  state_t s_reg;
  state_t s_next;

  logic [15:0] key;
  logic        tick_now;
  logic [7:0]  err_bits;
  logic        err_any;
  logic [32:0] rem;
  logic [32:0] mag;
  logic [15:0] acc_step;
  logic [15:0] dec_step;
  logic [15:0] vmax;
  logic [49:0] brake_lhs;
  logic [49:0] brake_rhs;
  logic [16:0] spd_sum;
  logic [15:0] spd_new;
  logic [32:0] step;
  logic        abs_wr;
  logic        rel_wr;
  logic        cmd_wr;
  logic        size_wr;
  logic        gear_run;

  // Ramp in r.p.m/s to a per-cycle step, never zero so a move always ends
  function automatic logic [15:0] ramp_step(input logic [31:0] ramp);
    logic [31:0] sh;
    sh = ramp >> RAMP_SHIFT;
    if (sh > 32'h0000_ffff)
      return 16'hffff;
    else if (sh == 32'h0000_0000)
      return 16'h0001;
    else
      return sh[15:0];
  endfunction

  function automatic logic [15:0] speed_clamp(input logic [31:0] v);
    logic [31:0] a;
    a = v[31] ? (32'h0000_0000 - v) : v;
    if (a > {16'h0000, SPEED_LIMIT})
      return SPEED_LIMIT;
    else if (a == 32'h0000_0000)
      return 16'h0001;
    else
      return a[15:0];
  endfunction

  assign key      = {param_index_in, param_subindex_in};
  assign tick_now = (s_reg.tick == 20'(CTRL_CLKS - 1));
  // Bit 4 stays clear
  assign err_bits = {soft_stop_in, soft_negative_limit_in, soft_positive_limit_in, 1'b0,
                     reference_switch_stop_in, hardware_stop_input_in,
                     negative_limit_switch_in, positive_limit_switch_in};
  assign err_any  = |err_bits;
  assign abs_wr   = param_wr_in && (key == KEY_ABS_TARGET);
  assign rel_wr   = param_wr_in && (key == KEY_REL_TRAVEL);
  assign cmd_wr   = abs_wr || rel_wr;
  assign size_wr  = param_wr_in && (key == KEY_ORIGIN_SIZE);
  assign gear_run = gear_mode_in && gear_proc_active_in;

  always_comb
  begin
    s_next = s_reg;
    rem       = 33'h0_0000_0000;
    mag       = 33'h0_0000_0000;
    brake_lhs = 50'h0;
    brake_rhs = 50'h0;
    spd_sum   = 17'h0_0000;
    spd_new   = 16'h0000;
    step      = 33'h0_0000_0000;
    acc_step  = ramp_step(s_reg.acc);
    dec_step  = ramp_step(s_reg.dec);
    vmax      = speed_clamp(s_reg.spd_set);
    s_next.tick   = tick_now ? 20'h0_0000 : s_reg.tick + 20'h0_0001;
    s_next.err    = 1'b0;
    s_next.preset = 1'b0;

    // Parameter writes; values are raw increments, no scaling
    if (param_wr_in)
    begin
      case (key)
        KEY_ABS_TARGET:  s_next.abs_tgt = param_wdata_in;
        KEY_REL_TRAVEL:  s_next.rel_trv = param_wdata_in;
        KEY_SPEED_SET:   s_next.spd_set = param_wdata_in;
        KEY_ACCEL_RAMP:  s_next.acc     = param_wdata_in;
        KEY_DECEL_RAMP:  s_next.dec     = param_wdata_in;
        KEY_ORIGIN_SIZE:
        begin
          // Shift origin but keep applied offset unchanged
          s_next.sizing = param_wdata_in;
          s_next.delta  = s_reg.pos + s_reg.delta - param_wdata_in;
          s_next.pos    = param_wdata_in;
          s_next.tgt    = param_wdata_in + (s_reg.tgt - s_reg.pos);
        end
        KEY_REF_START:
        begin
          // Referencing requested by the master over the parameter channel
          if (s_reg.refs == REF_IDLE && param_wdata_in[31:4] == 28'h000_0000
              && param_wdata_in[3:0] != 4'h0 && param_wdata_in[3:0] <= REF_TYPE_MAX)
          begin
            s_next.refs     = REF_MOVE;
            s_next.ref_type = param_wdata_in[3:0];
            s_next.ref_ok   = 1'b0;
            s_next.ref_stat = 16'h0000;
          end
          else
            s_next.err = 1'b1;
        end
        KEY_DIM_SET:
        begin
          // Only at standstill and never during a reference movement
          if (s_reg.refs == REF_IDLE && standstill_in)
          begin
            s_next.preset     = 1'b1;
            s_next.preset_val = param_wdata_in;
            s_next.ref_ok     = 1'b1;
            s_next.ref_stat   = 16'h0000;
            s_next.ref_stat[BIT_MOTION_END] = 1'b1;
          end
          else
            s_next.err = 1'b1;
        end
        default: s_next.err = 1'b1;
      endcase
    end

    // New command: absolute or relative, freely mixed
    if (cmd_wr)
    begin
      s_next.tgt      = abs_wr ? param_wdata_in : s_reg.tgt + param_wdata_in;
      s_next.ofs_stat = 16'h0000;
      if (gear_run)
        s_next.ofs = OFS_RUN;
      else
      begin
        // Gear processing off: jump straight to target, no ramps
        s_next.pos = s_next.tgt;
        s_next.spd = 16'h0000;
        s_next.ofs = OFS_IDLE;
        s_next.ofs_stat[BIT_SET_REACHED] = 1'b1;
        s_next.ofs_stat[BIT_MOTION_END]  = 1'b1;
      end
    end

    // Ramp generator, one step per control cycle
    // Sizing rewrites pos itself, so that cycle's tick is skipped
    if (s_reg.ofs == OFS_RUN && tick_now && !cmd_wr && !size_wr)
    begin
      rem = {s_reg.tgt[31], s_reg.tgt} - {s_reg.pos[31], s_reg.pos};
      mag = rem[32] ? (33'h0_0000_0000 - rem) : rem;
      if (mag == 33'h0_0000_0000)
      begin
        s_next.ofs = OFS_IDLE;
        s_next.spd = 16'h0000;
        s_next.ofs_stat[BIT_SET_REACHED] = 1'b1;
        s_next.ofs_stat[BIT_MOTION_END]  = 1'b1;
      end
      else
      begin
        // Brake once stopping distance spd^2/2dec reaches the remainder
        brake_lhs = 50'(s_reg.spd) * 50'(s_reg.spd);
        brake_rhs = (50'(dec_step) * 50'(mag)) << 1;
        spd_sum   = {1'b0, s_reg.spd} + {1'b0, acc_step};
        if (brake_lhs >= brake_rhs)
          spd_new = (s_reg.spd > dec_step) ? s_reg.spd - dec_step : 16'h0001;
        else if (spd_sum > {1'b0, vmax})
          spd_new = vmax;
        else
          spd_new = spd_sum[15:0];
        step = ({17'h0_0000, spd_new} > mag) ? mag : {17'h0_0000, spd_new};
        s_next.spd     = spd_new;
        s_next.dir_neg = rem[32];
        s_next.pos     = rem[32] ? s_reg.pos - step[31:0] : s_reg.pos + step[31:0];
      end
    end

    // Completion wins over aborts in the same cycle
    if (s_next.ofs == OFS_RUN && (!gear_mode_in || err_any))
    begin
      s_next.ofs = OFS_IDLE;
      s_next.spd = 16'h0000;
      s_next.tgt = s_next.pos;
      s_next.ofs_stat[7:0] = s_reg.ofs_stat[7:0] | err_bits;
      s_next.ofs_stat[BIT_MOTION_END] = 1'b1;
      s_next.ofs_stat[BIT_MOTION_ERR] = 1'b1;
    end

    // Reference movement outcome
    if (s_reg.refs == REF_MOVE)
    begin
      if (ref_move_done_in)
      begin
        s_next.refs   = REF_IDLE;
        s_next.ref_ok = 1'b1;
        s_next.ref_stat[BIT_MOTION_END] = 1'b1;
      end
      else if (ref_move_fail_in)
      begin
        // Interrupted: point stays invalid until a full rerun or a dimension setting
        s_next.refs = REF_IDLE;
        s_next.ref_stat[7:0] = err_bits;
        s_next.ref_stat[BIT_MOTION_END] = 1'b1;
        s_next.ref_stat[BIT_MOTION_ERR] = 1'b1;
      end
    end

    s_next.applied  = s_next.pos + s_next.delta;
    s_next.setpoint = gear_setpoint_in + s_next.applied;

    if (param_rd_in)
    begin
      s_next.err = 1'b0;
      case (key)
        KEY_ABS_TARGET:   s_next.rdata = s_reg.abs_tgt;
        KEY_OFS_STATUS:   s_next.rdata = {16'h0000, s_reg.ofs_stat};
        KEY_REL_TRAVEL:   s_next.rdata = s_reg.rel_trv;
        KEY_SPEED_SET:    s_next.rdata = s_reg.spd_set;
        KEY_ORIGIN_SIZE:  s_next.rdata = s_reg.sizing;
        KEY_ACCEL_RAMP:   s_next.rdata = s_reg.acc;
        KEY_DECEL_RAMP:   s_next.rdata = s_reg.dec;
        KEY_MON_TARGET:   s_next.rdata = s_reg.tgt;
        KEY_MON_POSITION: s_next.rdata = s_reg.pos;
        KEY_MON_SPEED:
          s_next.rdata = s_reg.dir_neg ? 32'h0000_0000 - {16'h0000, s_reg.spd}
                                       : {16'h0000, s_reg.spd};
        KEY_REF_START:    s_next.rdata = {28'h000_0000, s_reg.ref_type};
        KEY_REF_STATUS:   s_next.rdata = {16'h0000, s_reg.ref_stat};
        KEY_MODE_STATUS:  s_next.rdata = 32'(s_reg.ref_ok) << BIT_REF_OK;
        default:
        begin
          s_next.rdata = 32'h0000_0000;
          s_next.err   = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      s_reg <= '{ofs: OFS_IDLE, refs: REF_IDLE, tick: 20'h0_0000,
                 abs_tgt: RST_ABS_TARGET, rel_trv: RST_REL_TRAVEL,
                 spd_set: RST_SPEED_SET, acc: RST_ACCEL_RAMP, dec: RST_DECEL_RAMP,
                 sizing: RST_ORIGIN_SIZE, tgt: 32'h0000_0000, pos: 32'h0000_0000,
                 delta: 32'h0000_0000, spd: 16'h0000, dir_neg: 1'b0,
                 ofs_stat: 16'h0000, ref_stat: 16'h0000, ref_ok: 1'b0,
                 ref_type: 4'h0, preset: 1'b0, preset_val: 32'h0000_0000,
                 applied: 32'h0000_0000, setpoint: 32'h0000_0000,
                 rdata: 32'h0000_0000, err: 1'b0};
    end
    else
      s_reg <= s_next;
  end

  assign param_rdata_out       = s_reg.rdata;
  assign param_err_out         = s_reg.err;
  assign position_setpoint_out = s_reg.setpoint;
  assign ref_move_req_out      = (s_reg.refs == REF_MOVE);
  assign ref_move_type_out     = s_reg.ref_type;
  assign mode_change_lock_out  = (s_reg.refs == REF_MOVE);
  assign pos_preset_out        = s_reg.preset;
  assign pos_preset_value_out  = s_reg.preset_val;

  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (!rst_b_in);

  chk_setpoint_sum: assert property (
    $past(rst_b_in) |-> position_setpoint_out == $past(gear_setpoint_in) + s_reg.applied)
    else $error("setpoint is not gear input plus offset");

  chk_cmd_starts_run: assert property (
    cmd_wr && gear_run && !err_any |=> s_reg.ofs == OFS_RUN)
    else $error("offset command did not start a move");

  chk_mode_abort: assert property (
    s_reg.ofs == OFS_RUN && !gear_mode_in |=> s_reg.ofs == OFS_IDLE && s_reg.spd == 16'h0000)
    else $error("offset move not aborted on mode change");

  chk_direct_apply: assert property (
    abs_wr && !gear_run |=> s_reg.pos == $past(param_wdata_in) && s_reg.ofs == OFS_IDLE)
    else $error("direct offset not applied");

  chk_sizing_no_move: assert property (
    param_wr_in && key == KEY_ORIGIN_SIZE && !cmd_wr
    |=> s_reg.applied == $past(s_reg.applied) && s_reg.pos == $past(param_wdata_in))
    else $error("sizing moved the motor");

  chk_status_bit4: assert property (
    s_reg.ofs_stat[BIT_UNUSED] == 1'b0)
    else $error("unused status bit set");

  chk_speed_limit: assert property (
    s_reg.spd <= SPEED_LIMIT)
    else $error("offset speed above limit");

  chk_accel_step: assert property (
    s_reg.ofs == OFS_RUN ##1 s_reg.spd > $past(s_reg.spd)
    |-> s_reg.spd - $past(s_reg.spd) <= ramp_step(s_reg.acc))
    else $error("acceleration step too large");

  chk_cmd_clears: assert property (
    cmd_wr && gear_run && !err_any |=> !s_reg.ofs_stat[BIT_MOTION_ERR])
    else $error("stale status after new command");

  chk_ref_valid: assert property (
    s_reg.refs == REF_MOVE && ref_move_done_in |=> s_reg.ref_ok ##0 !mode_change_lock_out)
    else $error("reference valid bit not set");

  chk_ref_restart: assert property (
    s_reg.refs == REF_MOVE && !ref_move_done_in |=> !s_reg.ref_ok)
    else $error("reference valid before movement completed");

  chk_dim_preset: assert property (
    param_wr_in && key == KEY_DIM_SET && s_reg.refs == REF_IDLE && standstill_in
    |=> pos_preset_out && pos_preset_value_out == $past(param_wdata_in)
    ##1 (!pos_preset_out || $past(param_wr_in && key == KEY_DIM_SET)))
    else $error("dimension set preset not issued");

  cov_move_done: cover property (
    s_reg.ofs == OFS_RUN ##1 s_reg.ofs == OFS_IDLE && s_reg.ofs_stat[BIT_SET_REACHED]);
  cov_move_abort: cover property (
    s_reg.ofs == OFS_RUN && !gear_mode_in);
  cov_ref_done: cover property (
    s_reg.refs == REF_MOVE && ref_move_done_in);
  cov_dim_set: cover property (pos_preset_out);

endmodule
